// *** hdl/hsqw_pkg.sv ***
// Constants, field layouts and carrier types for the status queue writer.
// Assumes a 16-bit shared memory addressed in bytes, words on even addresses.
package hsqw_pkg;

  // ---------------------------------------------------------------
  // Widths and offsets
  // ---------------------------------------------------------------
  localparam int AW = 24;
  localparam logic [AW-1:0] DESC_STAT_OFS = 24'h00000a;
  localparam logic [15:0] TS_RST = 16'h0000;
  localparam logic [15:0] PTR_RST = 16'h0000;

  // ---------------------------------------------------------------
  // Entry and status word field positions
  // ---------------------------------------------------------------
  localparam int NS_BIT = 15;
  localparam int DIR_BIT = 13;
  localparam int CH_LSB = 8;
  localparam int SENT_OK_BIT = 15;
  localparam int ABORTED_BIT = 14;
  localparam int STARVED_BIT = 13;

  // Event source codes of a command/indicate entry
  localparam logic [1:0] SRC_PRIM = 2'h0;
  localparam logic [1:0] SRC_AES = 2'h1;
  localparam logic [1:0] SRC_ALARM = 2'h2;
  localparam logic [1:0] SRC_RSVD = 2'h3;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_DESC = 3'h1,
    ST_RDNS = 3'h3,
    ST_WTS = 3'h2,
    ST_WENT = 3'h6
  } hsqw_st_t;

  typedef enum logic [1:0] {
    SEL_TX = 2'h0,
    SEL_RX = 2'h1,
    SEL_CI = 2'h2
  } hsqw_sel_t;

  typedef struct packed {
    logic [AW-1:0] desc_addr;
    logic [4:0] chan;
    logic frame_end;
    logic frame_good;
    logic aborted;
    logic starved;
    logic buf_drained;
    logic irq_en;
    logic queue_end_flag;
    logic halt;
    logic abort_cmd;
  } hsqw_tx_evt_t;

  typedef struct packed {
    logic [4:0] chan;
    logic frame_end;
    logic crc_ok;
    logic aborted;
    logic overflow;
    logic buf_filled;
    logic irq_en;
    logic queue_end_flag;
    logic halt;
    logic abort_idle;
  } hsqw_rx_evt_t;

  typedef struct packed {
    logic [1:0] src;
    logic port;
    logic [2:0] chan;
    logic [5:0] bits;
  } hsqw_ci_smp_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [AW-1:0] addr;
    logic [15:0] wdata;
  } hsqw_mem_t;

  typedef struct packed {
    hsqw_st_t st;
    hsqw_sel_t sel;
    hsqw_mem_t mem;
    logic tx_free;
    logic rx_free;
    logic ci_free;
    hsqw_tx_evt_t tx;
    hsqw_rx_evt_t rx;
    logic [15:0] ci_word;
    logic [15:0] ci_ts;
    logic ci_two;
    logic [15:0] entry;
    logic [15:0] hq_ptr;
    logic [15:0] cq_ptr;
    logic ovf_h;
    logic ovf_c;
    logic tx_halt;
    logic rx_halt;
    logic [15:0] ts;
    logic [31:0][5:0] cand;
    logic [31:0][5:0] stab;
    logic [31:0] seen;
    logic [31:0] rep;
    logic [AW-1:0] fetch_addr;
    logic fetch_hi;
  } hsqw_state_t;

endpackage

// *** hdl/hsqw_writer.sv ***
// Status queue writer: posts transmit/receive HDLC and command/indicate
// events into shared-memory queues, with descriptor status and byte locator.
// Assumes one memory port on the same clock; ack is a one-cycle pulse.
`timescale 1ns/100ps

module hsqw_writer (
  input logic clk,
  input logic rst,
  input logic tx_valid,
  input hsqw_pkg::hsqw_tx_evt_t tx_evt,
  output logic tx_ready,
  input logic rx_valid,
  input hsqw_pkg::hsqw_rx_evt_t rx_evt,
  output logic rx_ready,
  input logic ci_valid,
  input hsqw_pkg::hsqw_ci_smp_t ci_smp,
  input logic timestamp_enable,
  input logic tx_continue,
  input logic rx_continue,
  output logic tx_stalled,
  output logic rx_stalled,
  input logic [hsqw_pkg::AW-1:0] hq_base,
  input logic [15:0] hq_size,
  input logic [hsqw_pkg::AW-1:0] cq_base,
  input logic [15:0] cq_size,
  input logic hdlc_ovf_clr,
  input logic ci_ovf_clr,
  output logic hdlc_queue_overflow,
  output logic ci_queue_overflow,
  output hsqw_pkg::hsqw_mem_t mem,
  input logic mem_ack,
  input logic [15:0] mem_rdata,
  input logic [hsqw_pkg::AW-1:0] tx_buffer_pointer,
  input logic [11:0] fetch_idx,
  output logic [hsqw_pkg::AW-1:0] fetch_addr,
  output logic fetch_hi
);
  import hsqw_pkg::*;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [AW-1:0] slot(input logic [AW-1:0] base,
                                        input logic [15:0] ptr);
    slot = base + {7'h00, ptr, 1'b0};
  endfunction

  // Ring wrap to 0 once ptr plus len reaches size; a two-word entry at the last word runs past the end
  function automatic logic [15:0] qnext(input logic [15:0] ptr,
                                        input logic [15:0] len,
                                        input logic [15:0] size);
    logic [16:0] sum;
    sum = {1'b0, ptr} + {1'b0, len};
    qnext = (sum >= {1'b0, size}) ? 16'h0000 : sum[15:0];
  endfunction

  function automatic hsqw_mem_t mrd(input logic [AW-1:0] a);
    mrd = '{req: 1'b1, we: 1'b0, addr: a, wdata: 16'h0000};
  endfunction

  function automatic hsqw_mem_t mwr(input logic [AW-1:0] a,
                                    input logic [15:0] d);
    mwr = '{req: 1'b1, we: 1'b1, addr: a, wdata: d};
  endfunction

  function automatic logic [4:0] tx_flags(input hsqw_tx_evt_t e);
    logic ok;
    ok = e.frame_end & e.frame_good & ~e.aborted & ~e.starved;
    tx_flags = {ok & e.irq_en,
                e.buf_drained & e.irq_en,
                e.halt, e.queue_end_flag, e.abort_cmd};
  endfunction

  function automatic logic [4:0] rx_flags(input hsqw_rx_evt_t e);
    logic bad;
    bad = ~e.crc_ok | e.aborted | e.overflow;
    rx_flags = {e.frame_end & ~bad,
                e.buf_filled & e.irq_en,
                e.halt | e.abort_idle,
                e.queue_end_flag,
                e.frame_end & bad};
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  hsqw_state_t s_r;
  hsqw_state_t s_nxt;

  logic [4:0] idx;
  logic hit;
  logic fin;
  logic [4:0] fl;
  logic [11:0] bidx;

  always_comb begin
    s_nxt = s_r;
    idx = {ci_smp.src[0], ci_smp.port, ci_smp.chan};
    hit = 1'b0;
    fin = 1'b0;
    fl = 5'h00;
    bidx = fetch_idx;
    s_nxt.ts = s_r.ts + 16'h0001;

    // Byte locator for the transmit buffer; byte k of a count of n
    // lands low for even k, so the last one follows the odd/even split
    s_nxt.fetch_addr = tx_buffer_pointer + {12'h000, bidx[11:1], 1'b0};
    s_nxt.fetch_hi = bidx[0];

    // Event capture, one slot per source
    if (s_r.tx_free && tx_valid) begin
      s_nxt.tx_free = 1'b0;
      s_nxt.tx = tx_evt;
    end
    if (s_r.rx_free && rx_valid) begin
      s_nxt.rx_free = 1'b0;
      s_nxt.rx = rx_evt;
    end

    // ---------------------------------------------------------------
    // Command/indicate change detection
    // ---------------------------------------------------------------
    if (ci_valid && ci_smp.src != SRC_RSVD) begin
      if (ci_smp.src == SRC_ALARM) begin
        hit = 1'b1;
      end else begin
        hit = s_r.seen[idx] && s_r.cand[idx] == ci_smp.bits &&
              !(s_r.rep[idx] && s_r.stab[idx] == ci_smp.bits);
        s_nxt.cand[idx] = ci_smp.bits;
        s_nxt.seen[idx] = 1'b1;
      end
      // A busy slot leaves the change unrecorded, so it is seen again
      if (hit && s_r.ci_free) begin
        s_nxt.ci_free = 1'b0;
        s_nxt.ci_ts = s_r.ts;
        s_nxt.ci_two = timestamp_enable;
        s_nxt.ci_word = {1'b1, 1'b0,
                         timestamp_enable ? 2'b00 : ci_smp.src,
                         ci_smp.port, ci_smp.chan, 2'b00, ci_smp.bits};
        if (ci_smp.src != SRC_ALARM) begin
          s_nxt.stab[idx] = ci_smp.bits;
          s_nxt.rep[idx] = 1'b1;
        end
      end
    end

    // Clears come first so that a same-cycle set wins
    if (tx_continue) begin
      s_nxt.tx_halt = 1'b0;
    end
    if (rx_continue) begin
      s_nxt.rx_halt = 1'b0;
    end
    if (hdlc_ovf_clr) begin
      s_nxt.ovf_h = 1'b0;
    end
    if (ci_ovf_clr) begin
      s_nxt.ovf_c = 1'b0;
    end

    // ---------------------------------------------------------------
    // Memory sequencer
    // ---------------------------------------------------------------
    unique case (s_r.st)
      ST_IDLE: begin
        if (!s_r.tx_free) begin
          s_nxt.sel = SEL_TX;
          fl = tx_flags(s_r.tx);
          s_nxt.entry = {1'b1, 1'b0, 1'b1, s_r.tx.chan, 3'h0, fl};
          if (s_r.tx.queue_end_flag || s_r.tx.halt || s_r.tx.abort_cmd) begin
            s_nxt.tx_halt = 1'b1;
          end
          if (s_r.tx.frame_end) begin
            s_nxt.st = ST_DESC;
            s_nxt.mem = mwr(s_r.tx.desc_addr + DESC_STAT_OFS,
                            {s_r.tx.frame_good & ~s_r.tx.aborted &
                             ~s_r.tx.starved,
                             s_r.tx.aborted,
                             s_r.tx.starved,
                             13'h0000});
          end else if (fl != 5'h00) begin
            s_nxt.st = ST_RDNS;
            s_nxt.mem = mrd(slot(hq_base, s_r.hq_ptr));
          end else begin
            s_nxt.tx_free = 1'b1;
          end
        end else if (!s_r.rx_free) begin
          s_nxt.sel = SEL_RX;
          fl = rx_flags(s_r.rx);
          s_nxt.entry = {1'b1, 1'b0, 1'b0, s_r.rx.chan, 3'h0, fl};
          if (s_r.rx.queue_end_flag || s_r.rx.halt || s_r.rx.abort_idle) begin
            s_nxt.rx_halt = 1'b1;
          end
          if (fl != 5'h00) begin
            s_nxt.st = ST_RDNS;
            s_nxt.mem = mrd(slot(hq_base, s_r.hq_ptr));
          end else begin
            s_nxt.rx_free = 1'b1;
          end
        end else if (!s_r.ci_free) begin
          s_nxt.sel = SEL_CI;
          s_nxt.entry = s_r.ci_word;
          s_nxt.st = ST_RDNS;
          s_nxt.mem = mrd(slot(cq_base, s_r.cq_ptr));
        end
      end
      ST_DESC: begin
        if (mem_ack) begin
          if (s_r.entry[4:0] != 5'h00) begin
            s_nxt.st = ST_RDNS;
            s_nxt.mem = mrd(slot(hq_base, s_r.hq_ptr));
          end else begin
            s_nxt.mem.req = 1'b0;
            s_nxt.st = ST_IDLE;
            fin = 1'b1;
          end
        end
      end
      ST_RDNS: begin
        if (mem_ack) begin
          if (mem_rdata[NS_BIT]) begin
            // Slot still owned by software: drop the entry, keep pointer
            s_nxt.mem.req = 1'b0;
            s_nxt.st = ST_IDLE;
            fin = 1'b1;
            if (s_r.sel == SEL_CI) begin
              s_nxt.ovf_c = 1'b1;
            end else begin
              s_nxt.ovf_h = 1'b1;
            end
          end else if (s_r.sel == SEL_CI && s_r.ci_two) begin
            // Stamp word first, so the fresh word is the last one seen
            s_nxt.st = ST_WTS;
            s_nxt.mem = mwr(slot(cq_base, s_r.cq_ptr + 16'h0001), s_r.ci_ts);
          end else begin
            s_nxt.st = ST_WENT;
            s_nxt.mem = mwr(slot(s_r.sel == SEL_CI ? cq_base : hq_base,
                                 s_r.sel == SEL_CI ? s_r.cq_ptr : s_r.hq_ptr),
                            s_r.entry);
          end
        end
      end
      ST_WTS: begin
        if (mem_ack) begin
          s_nxt.st = ST_WENT;
          s_nxt.mem = mwr(slot(cq_base, s_r.cq_ptr), s_r.entry);
        end
      end
      ST_WENT: begin
        if (mem_ack) begin
          s_nxt.mem.req = 1'b0;
          s_nxt.st = ST_IDLE;
          fin = 1'b1;
          if (s_r.sel == SEL_CI) begin
            s_nxt.cq_ptr = qnext(s_r.cq_ptr, s_r.ci_two ? 16'h0002 : 16'h0001, cq_size);
          end else begin
            s_nxt.hq_ptr = qnext(s_r.hq_ptr, 16'h0001, hq_size);
          end
        end
      end
    endcase

    if (fin) begin
      unique case (s_r.sel)
        SEL_TX: s_nxt.tx_free = 1'b1;
        SEL_RX: s_nxt.rx_free = 1'b1;
        default: s_nxt.ci_free = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
      s_r.st <= ST_IDLE;
      s_r.sel <= SEL_TX;
      s_r.tx_free <= 1'b1;
      s_r.rx_free <= 1'b1;
      s_r.ci_free <= 1'b1;
      s_r.ts <= TS_RST;
      s_r.hq_ptr <= PTR_RST;
      s_r.cq_ptr <= PTR_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign tx_ready = s_r.tx_free;
  assign rx_ready = s_r.rx_free;
  assign tx_stalled = s_r.tx_halt;
  assign rx_stalled = s_r.rx_halt;
  assign hdlc_queue_overflow = s_r.ovf_h;
  assign ci_queue_overflow = s_r.ovf_c;
  assign mem = s_r.mem;
  assign fetch_addr = s_r.fetch_addr;
  assign fetch_hi = s_r.fetch_hi;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_busy_slot;
    s_r.st == ST_RDNS && mem_ack && mem_rdata[NS_BIT];
  endsequence

  sequence s_stamp_done;
    s_r.st == ST_WTS && mem_ack;
  endsequence

  a_ovf_raise: assert property (s_busy_slot ##0 (s_r.sel != SEL_CI)
    |=> hdlc_queue_overflow && s_r.st == ST_IDLE)
    else $error("hdlc overflow not raised on busy slot");

  a_ovf_sticky: assert property (ci_queue_overflow && !ci_ovf_clr
    |=> ci_queue_overflow)
    else $error("ci overflow dropped without clear");

  a_entry_fresh: assert property (s_r.st == ST_WENT && mem.req
    |-> mem.we && mem.wdata[NS_BIT] && $past(s_r.st) != ST_IDLE)
    else $error("entry written without fresh flag");

  a_entry_zeros: assert property (s_r.st == ST_WENT && s_r.sel != SEL_CI
    |-> mem.wdata[14] == 1'b0 && mem.wdata[7:5] == 3'h0)
    else $error("hdlc entry reserved bits not zero");

  a_entry_dir: assert property (s_r.st == ST_WENT && s_r.sel != SEL_CI
    |-> mem.wdata[DIR_BIT] == (s_r.sel == SEL_TX))
    else $error("direction bit wrong");

  a_desc_word: assert property (s_r.st == ST_DESC
    |-> mem.addr == s_r.tx.desc_addr + DESC_STAT_OFS && mem.wdata[12:0] == 13'h0000
        && mem.wdata[SENT_OK_BIT] != (s_r.tx.aborted | s_r.tx.starved | ~s_r.tx.frame_good))
    else $error("descriptor status word wrong");

  a_stamp_order: assert property (s_stamp_done
    |=> s_r.st == ST_WENT && mem.addr + 24'h000002 == $past(mem.addr))
    else $error("stamp word not followed by first word");

  a_halt_hold: assert property (tx_stalled && !tx_continue
    |=> tx_stalled)
    else $error("transmit stall released without continue");

  a_stamp_count: assert property (s_r.ts == 16'hffff |=> s_r.ts == 16'h0000)
    else $error("stamp counter did not wrap");

  a_fetch_lane: assert property (fetch_addr[0] == tx_buffer_pointer[0] ^ 1'b0
    |-> fetch_hi == $past(fetch_idx[0]))
    else $error("byte lane of fetch wrong");

endmodule

// *** verif/hsqw_mem_model.sv ***
// Shared memory partner: word store answering the writer's memory port.
// Assumes byte addresses below 8 KiB; lat sets the ack delay in cycles.
`timescale 1ns/100ps
module hsqw_mem_model (
  input logic clk,
  input logic rst,
  input logic [3:0] lat,
  input hsqw_pkg::hsqw_mem_t mem,
  output logic mem_ack,
  output logic [15:0] mem_rdata
);
  import hsqw_pkg::*;
  logic [15:0] words [0:4095];
  logic [3:0] cnt;
  logic [15:0] last;
  initial begin
    for (int i = 0; i < 4096; i++) words[i] = 16'h0000;
  end
  // Idle bus shows the inverse of the word seen at the last acked read or write, never a stale copy
  assign mem_rdata = mem_ack ? words[mem.addr[12:1]] : ~last;
  always @(posedge clk) begin
    if (rst) begin
      mem_ack <= 1'b0;
      cnt <= 4'h0;
      last <= 16'h0000;
    end else if (mem_ack) begin
      mem_ack <= 1'b0;
      cnt <= 4'h0;
      last <= mem_rdata;
      if (mem.we) words[mem.addr[12:1]] <= mem.wdata;
    end else if (mem.req) begin
      if (cnt >= lat) mem_ack <= 1'b1;
      else cnt <= cnt + 4'h1;
    end
  end
endmodule

// *** verif/tb.sv ***
// Self-checking bench for the status queue writer.
// Assumes the memory model stands in for the shared memory and host.
`timescale 1ns/100ps
module tb;
  import hsqw_pkg::*;
  typedef struct packed {
    logic is_rx;
    hsqw_tx_evt_t tx;
    hsqw_rx_evt_t rx;
    logic [3:0] lat;
    logic [16:0] desc;
    logic [15:0] entry;
    logic stall;
  } hsqw_row_t;
  localparam logic [23:0] HQ = 24'h000100;
  localparam logic [23:0] CQ = 24'h000300;
  logic clk, rst, tx_valid, tx_ready, rx_valid, rx_ready, ci_valid, timestamp_enable;
  logic tx_continue, rx_continue, tx_stalled, rx_stalled, hdlc_ovf_clr, ci_ovf_clr;
  logic hdlc_queue_overflow, ci_queue_overflow, mem_ack, fetch_hi;
  logic [3:0] lat;
  logic [15:0] mem_rdata, t1, c1, cy;
  logic [15:0] cyc = 16'h0000;
  logic [11:0] fetch_idx;
  logic [23:0] tx_buffer_pointer, fetch_addr, slot;
  hsqw_tx_evt_t tx_evt;
  hsqw_rx_evt_t rx_evt;
  hsqw_ci_smp_t ci_smp;
  hsqw_mem_t mem;
  hsqw_row_t rows [0:14];
  hsqw_row_t row;
  int error_cnt, cmp_count, hidx, cidx;
  int ks [0:4];

  hsqw_writer dut (.clk(clk), .rst(rst), .tx_valid(tx_valid), .tx_evt(tx_evt),
    .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_evt(rx_evt), .rx_ready(rx_ready),
    .ci_valid(ci_valid), .ci_smp(ci_smp), .timestamp_enable(timestamp_enable),
    .tx_continue(tx_continue), .rx_continue(rx_continue), .tx_stalled(tx_stalled),
    .rx_stalled(rx_stalled), .hq_base(HQ), .hq_size(16'h0010), .cq_base(CQ),
    .cq_size(16'h0010), .hdlc_ovf_clr(hdlc_ovf_clr), .ci_ovf_clr(ci_ovf_clr),
    .hdlc_queue_overflow(hdlc_queue_overflow), .ci_queue_overflow(ci_queue_overflow),
    .mem(mem), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .tx_buffer_pointer(tx_buffer_pointer), .fetch_idx(fetch_idx),
    .fetch_addr(fetch_addr), .fetch_hi(fetch_hi));
  hsqw_mem_model u_mem (.clk(clk), .rst(rst), .lat(lat), .mem(mem), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata));

  initial clk = 1'b0;
  always #10 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 16'h0001;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic step;
    @(posedge clk);
    #1;
  endtask
  task automatic end_sim;
    if (error_cnt == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic [15:0] w(input logic [23:0] a);
    return u_mem.words[a[12:1]];
  endfunction
  function automatic hsqw_row_t r(input logic x, input logic [4:0] c, input logic [8:0] f,
      input logic [3:0] l, input logic [16:0] d, input logic [15:0] e, input logic s);
    r = '{x, {24'h000000, c, f}, {c, f}, l, d, e, s};
  endfunction
  // Holds valid until the taking edge, then waits for ready to come back
  task automatic send(input logic x, input hsqw_tx_evt_t t, input hsqw_rx_evt_t v);
    int n;
    n = 0;
    tx_evt = t;
    rx_evt = v;
    if (x) rx_valid = 1'b1;
    else tx_valid = 1'b1;
    step;
    rx_valid = 1'b0;
    tx_valid = 1'b0;
    while ((x ? rx_ready : tx_ready) !== 1'b1 && n < 100) begin
      step;
      n++;
    end
    chk("ready", x ? rx_ready : tx_ready, 1'b1);
    if (n == 100) end_sim;
  endtask
  task automatic ci_pulse(input logic [1:0] s, input logic p, input logic [2:0] c,
      input logic [5:0] b);
    ci_smp = {s, p, c, b};
    ci_valid = 1'b1;
    cy = cyc;
    step;
    ci_valid = 1'b0;
    step;
  endtask
  task automatic wait_word(input logic [23:0] a, input logic [15:0] e);
    int n;
    n = 0;
    while (w(a) !== e && n < 60) begin
      step;
      n++;
    end
    chk("ci_entry", w(a), e);
    if (n == 60) end_sim;
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {rst, tx_valid, rx_valid, ci_valid, timestamp_enable} = 5'h10;
    {tx_continue, rx_continue, hdlc_ovf_clr, ci_ovf_clr} = 4'h0;
    {tx_evt, rx_evt, ci_smp, lat, fetch_idx} = '0;
    tx_buffer_pointer = 24'h000000;
    {error_cnt, cmp_count, hidx, cidx} = '0;
    ks = '{0, 1, 2, 4094, 4095};
    rows[0] = r(0, 5, 9'b110001000, 0, 17'h18000, 16'ha510, 0);
    rows[1] = r(0, 6, 9'b111000000, 1, 17'h14000, 16'h0000, 0);
    rows[2] = r(0, 7, 9'b110100000, 2, 17'h12000, 16'h0000, 0);
    rows[3] = r(0, 31, 9'b000011000, 1, 0, 16'hbf08, 0);
    rows[4] = r(0, 0, 9'b000000100, 0, 0, 16'ha002, 1);
    rows[5] = r(0, 1, 9'b000000010, 3, 0, 16'ha104, 1);
    rows[6] = r(0, 2, 9'b000000001, 0, 0, 16'ha201, 1);
    rows[7] = r(1, 3, 9'b110001000, 0, 0, 16'h8310, 0);
    rows[8] = r(1, 4, 9'b101001000, 1, 0, 16'h8401, 0);
    rows[9] = r(1, 8, 9'b100101000, 0, 0, 16'h8801, 0);
    rows[10] = r(1, 9, 9'b100001000, 2, 0, 16'h8901, 0);
    rows[11] = r(1, 30, 9'b000011000, 0, 0, 16'h9e08, 0);
    rows[12] = r(1, 10, 9'b000000100, 0, 0, 16'h8a02, 1);
    rows[13] = r(1, 11, 9'b000000001, 1, 0, 16'h8b04, 1);
    rows[14] = r(1, 12, 9'b000000010, 0, 0, 16'h8c04, 1);
    repeat (20) step;
    rst = 1'b0;
    chk("rst_out", {tx_ready, rx_ready, tx_stalled, rx_stalled, mem.req}, 5'h18);
    chk("rst_ovf", {hdlc_queue_overflow, ci_queue_overflow}, 2'h0);
    chk("rst_fetch", fetch_addr, 24'h000000);
    step;
    for (int i = 0; i < 15; i++) begin
      row = rows[i];
      row.tx.desc_addr = 24'h000800 + 24'(i * 16);
      lat = row.lat;
      slot = HQ + 24'(hidx * 2);
      send(row.is_rx, row.tx, row.rx);
      if (row.desc[16])
        chk("desc", w(row.tx.desc_addr + DESC_STAT_OFS), row.desc[15:0]);
      chk("hdlc_entry", w(slot), row.entry);
      if (row.entry != 16'h0000) hidx++;
      chk("stall", row.is_rx ? rx_stalled : tx_stalled, row.stall);
      if (row.stall) begin
        {rx_continue, tx_continue} = row.is_rx ? 2'h2 : 2'h1;
        step;
        {rx_continue, tx_continue} = 2'h0;
        step;
        chk("resume", {rx_stalled, tx_stalled}, 2'h0);
      end
    end
    // Stale unread slot must not be overwritten
    slot = HQ + 24'(hidx * 2);
    u_mem.words[slot[12:1]] = 16'h8000;
    row = r(0, 4, 9'b000011000, 0, 0, 0, 0);
    send(0, row.tx, row.rx);
    repeat (60) if (hdlc_queue_overflow !== 1'b1) step;
    chk("h_ovf", hdlc_queue_overflow, 1'b1);
    chk("h_keep", w(slot), 16'h8000);
    hdlc_ovf_clr = 1'b1;
    step;
    hdlc_ovf_clr = 1'b0;
    step;
    chk("h_clr", hdlc_queue_overflow, 1'b0);
    u_mem.words[slot[12:1]] = 16'h0000;
    send(0, row.tx, row.rx);
    chk("h_retry", w(slot), 16'ha408);
    for (int k = 0; k < 4; k++) begin
      slot = CQ + 24'(cidx * 2);
      ci_pulse(k[1:0], k[0], 3'(k + 1), 6'(21 + k));
      if (k != 2) begin
        repeat (20) step;
        chk("ci_once", w(slot), 16'h0000);
        ci_pulse(k[1:0], k[0], 3'(k + 1), 6'(21 + k));
      end
      if (k == 3) begin
        repeat (30) step;
        chk("ci_rsvd", w(slot), 16'h0000);
      end else begin
        wait_word(slot, {2'b10, k[1:0], k[0], 3'(k + 1), 2'b00, 6'(21 + k)});
        cidx++;
      end
    end
    timestamp_enable = 1'b1;
    for (int k = 0; k < 2; k++) begin
      slot = CQ + 24'(cidx * 2);
      ci_pulse(2'h0, 1'b1, 3'h5, 6'(42 + k));
      ci_pulse(2'h0, 1'b1, 3'h5, 6'(42 + k));
      wait_word(slot, {8'h8d, 2'b00, 6'(42 + k)});
      if (k == 1) chk("ts_delta", w(slot + 24'h2) - t1, cy - c1);
      t1 = w(slot + 24'h2);
      c1 = cy;
      cidx += 2;
    end
    timestamp_enable = 1'b0;
    slot = CQ + 24'(cidx * 2);
    u_mem.words[slot[12:1]] = 16'h8000;
    ci_pulse(2'h2, 1'b0, 3'h7, 6'h00);
    repeat (60) if (ci_queue_overflow !== 1'b1) step;
    chk("ci_ovf", ci_queue_overflow, 1'b1);
    chk("ci_keep", w(slot), 16'h8000);
    ci_ovf_clr = 1'b1;
    step;
    ci_ovf_clr = 1'b0;
    step;
    chk("ci_clr", ci_queue_overflow, 1'b0);
    tx_buffer_pointer = 24'h001000;
    for (int i = 0; i < 5; i++) begin
      fetch_idx = 12'(ks[i]);
      step;
      chk("f_addr", fetch_addr, 24'h001000 + 24'(ks[i] / 2 * 2));
      chk("f_hi", fetch_hi, 24'(ks[i] % 2));
    end
    end_sim;
  end
endmodule
